// >>> verilog/dual_watchdog.sv
// Two independent watchdogs: standard timeout and windowed service.
// Assumes config and service come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dual_watchdog
  import wdog_pkg::*;
#(
  parameter int PULSE_CYC = NMI_PULSE_CYC
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire wdog_cfg_t stdCfg,
  input  wire logic      stdService,
  input  wire wdog_cfg_t winCfg,
  input  wire logic      winService,
  output logic           nmiReq,
  output logic           boardReset,
  output logic           stdTimeout,
  output logic           winEarly,
  output logic           winLate
);

  // ---------------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------------
  wdog_evt_t stdEvt;
  wdog_evt_t winEvt;

  wdog_timer #(.WINDOWED(1'b0)) uStd (
    .clk     (clk),
    .rst_n   (rst_n),
    .cfg     (stdCfg),
    .service (stdService),
    .evt     (stdEvt),
    .count   ()
  );

  wdog_timer #(.WINDOWED(1'b1)) uWin (
    .clk     (clk),
    .rst_n   (rst_n),
    .cfg     (winCfg),
    .service (winService),
    .evt     (winEvt),
    .count   ()
  );

  // ---------------------------------------------------------------------------
  // Fault decode
  // ---------------------------------------------------------------------------
  // One slot per action line, each with its own stretcher
  localparam int NUM_SINK = 2;
  localparam int SINK_NMI = 0;
  localparam int SINK_RST = 1;

  // Standard timer has no early case; expiry is its only fault
  wire stdHit = stdEvt.late;
  wire winHit = winEvt.early || winEvt.late;

  // Action read live, so a changed setting applies from the next fault on
  wire stdToNmi = stdHit && (stdCfg.action == ACT_NMI);
  wire stdToRst = stdHit && (stdCfg.action == ACT_RESET);
  wire winToNmi = winHit && (winCfg.action == ACT_NMI);
  wire winToRst = winHit && (winCfg.action == ACT_RESET);

  // Either timer may land on either line
  wire [NUM_SINK-1:0] sinkHit;

  assign sinkHit[SINK_NMI] = stdToNmi || winToNmi;
  assign sinkHit[SINK_RST] = stdToRst || winToRst;

  // ---------------------------------------------------------------------------
  // Pulse stretchers
  // ---------------------------------------------------------------------------
  // A fresh hit reloads the full length, so close faults merge into one pulse
  // rather than leaving a gap that a slow sink could miss.
  // Limitation: a PULSE_CYC of zero silences the action lines altogether.
  wire [NUM_SINK-1:0] sinkOn_nxt;

  for (genvar i = 0; i < NUM_SINK; i++) begin : gStretch
    logic [CNT_W-1:0] left_r;
    logic [CNT_W-1:0] left_nxt;
    wire              busy;

    assign busy     = left_r != '0;
    assign left_nxt = sinkHit[i] ? CNT_W'(PULSE_CYC) :
                      busy       ? left_r - 1'b1     :
                                   '0;
    assign sinkOn_nxt[i] = left_nxt != '0;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        left_r <= '0;
      end else begin
        left_r <= left_nxt;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Action outputs
  // ---------------------------------------------------------------------------
  // Taken from the stretcher's next value so the line rises together with
  // the event outputs instead of one clock behind them.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmiReq <= 1'h0;
    end else begin
      nmiReq <= sinkOn_nxt[SINK_NMI];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boardReset <= 1'h0;
    end else begin
      boardReset <= sinkOn_nxt[SINK_RST];
    end
  end

  // ---------------------------------------------------------------------------
  // Event outputs
  // ---------------------------------------------------------------------------
  // One clock behind the timer's own event flop; each stands one cycle, except a late flag, which stays high while timeout is zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stdTimeout <= 1'h0;
    end else begin
      stdTimeout <= stdEvt.late;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      winEarly <= 1'h0;
    end else begin
      winEarly <= winEvt.early;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      winLate <= 1'h0;
    end else begin
      winLate <= winEvt.late;
    end
  end

endmodule // dual_watchdog
`default_nettype wire

// >>> shared/wdog_pkg.sv
// Package for the dual watchdog block: timing defaults, actions, carriers.
// Assumes a single 40 MHz board clock shared by every user.
package wdog_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ      = 40;
  localparam int CNT_W        = 32;
  localparam int DEF_TMO_US   = 1000;
  localparam int DEF_TMO_CYC  = DEF_TMO_US * CLK_MHZ;
  localparam int DEF_OPEN_US  = 250;
  localparam int DEF_OPEN_CYC = DEF_OPEN_US * CLK_MHZ;
  localparam int NMI_PULSE_US  = 1;
  localparam int NMI_PULSE_CYC = NMI_PULSE_US * CLK_MHZ;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic RST_ENABLE = 1'b0;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic {ACT_NMI, ACT_RESET} action_t;

  typedef struct packed {
    logic              enable;
    action_t           action;
    logic [CNT_W-1:0]  timeout;
    logic [CNT_W-1:0]  winOpen;
  } wdog_cfg_t;

  typedef struct packed {
    logic early;
    logic late;
  } wdog_evt_t;

endpackage

// >>> verilog/wdog_timer.sv
// One watchdog counter; windowed or standard by parameter.
// Assumes service is a one-cycle pulse on clk from local logic.
`timescale 1ns/1ps
`default_nettype none
module wdog_timer
  import wdog_pkg::*;
#(
  parameter bit WINDOWED = 1'b0
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire wdog_cfg_t cfg,
  input  wire logic      service,
  output wdog_evt_t      evt,
  output logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wdog_evt_t        evt_r;
  wdog_evt_t        evt_nxt;

  wire expired  = cfg.enable && (cnt_r >= cfg.timeout);
  wire tooEarly = WINDOWED && cfg.enable && service
                  && (cnt_r < cfg.winOpen);
  wire inWindow = service && !tooEarly;

  // Any event or valid service restarts interval and window
  assign cnt_nxt = (!cfg.enable || inWindow || expired || tooEarly) ?
                   '0 : cnt_r + 1'b1;
  assign evt_nxt.early = tooEarly;
  assign evt_nxt.late  = expired && !inWindow;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      evt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign evt   = evt_r;
  assign count = cnt_r;

endmodule // wdog_timer
`default_nettype wire

// >>> tb/dual_watchdog_assertions.sv
// Checker for dual_watchdog: event routing, causes, quiet when disabled.
// Assumes it is bound to dual_watchdog and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dual_watchdog_assertions
  import wdog_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst_n,
  input wire wdog_cfg_t stdCfg,
  input wire logic      stdService,
  input wire wdog_cfg_t winCfg,
  input wire logic      winService,
  input wire logic      nmiReq,
  input wire logic      boardReset,
  input wire logic      stdTimeout,
  input wire logic      winEarly,
  input wire logic      winLate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence stdOff; !stdCfg.enable [*3]; endsequence
  sequence winOff; !winCfg.enable [*3]; endsequence
  std_nmi_a: assert property (stdTimeout && stdCfg.action == ACT_NMI |-> nmiReq)
    else $error("nmi missing");
  win_reset_a: assert property ((winEarly || winLate) && winCfg.action == ACT_RESET |-> boardReset)
    else $error("board reset missing");
  early_cause_a: assert property (winEarly |-> $past(winService, 2))
    else $error("early without service");
  std_quiet_a: assert property (stdOff |=> !stdTimeout)
    else $error("disabled std fired");
  win_quiet_a: assert property (winOff |=> !(winEarly || winLate))
    else $error("disabled win fired");
  std_pulse_a: assert property (stdTimeout && stdCfg.timeout > 2 |=> !stdTimeout)
    else $error("std timeout repeated");
  late_excl_a: assert property (winLate |-> !winEarly)
    else $error("early and late together");
endmodule // dual_watchdog_assertions
bind dual_watchdog dual_watchdog_assertions dual_watchdog_assertions_inst (.clk(clk),
  .rst_n(rst_n), .stdCfg(stdCfg), .stdService(stdService), .winCfg(winCfg),
  .winService(winService), .nmiReq(nmiReq), .boardReset(boardReset),
  .stdTimeout(stdTimeout), .winEarly(winEarly), .winLate(winLate));
`default_nettype wire

// >>> tb/tb_top.sv
// Bench for dual_watchdog: standard expiry, servicing, window faults.
// Assumes wdog_pkg is compiled first; the bench drives all ports.
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("mismatch %0t check", $time); end end
module tb_top;
  import wdog_pkg::*;
  logic      clk = 1'b0;
  logic      rst_n = 1'b0;
  wdog_cfg_t stdCfg = '0;
  wdog_cfg_t winCfg = '0;
  logic      stdService = 1'b0;
  logic      winService = 1'b0;
  logic      nmiReq, boardReset, stdTimeout, winEarly, winLate;
  int        fails = 0;
  int        tests_run = 0;
  integer    nS = 0, nE = 0, nL = 0, nN = 0, nB = 0, s, e, l, n, b;
  always #12.5 clk = ~clk;
  // Four-state tallies so an unknown output poisons every later check of its own tally
  always @(posedge clk) begin
    if (rst_n) begin
      nS <= nS + stdTimeout;
      nE <= nE + winEarly;
      nL <= nL + winLate;
      nN <= nN + nmiReq;
      nB <= nB + boardReset;
    end
  end
  // Short pulse keeps routing checks quick
  dual_watchdog #(.PULSE_CYC(2)) dual_watchdog_inst (.clk(clk), .rst_n(rst_n),
    .stdCfg(stdCfg), .stdService(stdService), .winCfg(winCfg), .winService(winService),
    .nmiReq(nmiReq), .boardReset(boardReset), .stdTimeout(stdTimeout),
    .winEarly(winEarly), .winLate(winLate));
  task cyc(int k); repeat (k) @(posedge clk); endtask
  task snap; s = nS; e = nE; l = nL; n = nN; b = nB; endtask
  task std_expiry_and_service;
    snap;
    stdCfg <= {1'b1, ACT_NMI, 32'h0000_0010, 32'h0000_0000};
    cyc(30);
    `CK(nS - s, 1)
    `CK(nN - n, 2)
    `CK(nB - b, 0)
    snap;
    repeat (8) begin
      stdService <= 1'b1; cyc(1); stdService <= 1'b0; cyc(7);
    end
    `CK(nS - s, 0)
    stdCfg <= '0;
  endtask
  task win_faults;
    snap;
    winCfg <= {1'b1, ACT_RESET, 32'h0000_0010, 32'h0000_0008};
    cyc(3); winService <= 1'b1; cyc(1); winService <= 1'b0; cyc(5);
    `CK(nE - e, 1)
    `CK(nB - b, 2)
    snap;
    repeat (4) begin
      cyc(11); winService <= 1'b1; cyc(1); winService <= 1'b0;
    end
    `CK(nE - e + nL - l, 0)
    cyc(25);
    `CK(nL - l, 1)
    `CK(nN - n + nS - s, 0)
  endtask
  task swapped_actions;
    snap;
    stdCfg <= {1'h1, ACT_RESET, 32'h0000_0004, 32'h0000_0000};
    winCfg <= {1'h1, ACT_NMI, 32'h0000_0040, 32'h0000_0020};
    winService <= 1'h1;
    cyc(1);
    winService <= 1'h0;
    cyc(6);
    stdCfg <= '0;
    winCfg <= '0;
    cyc(3);
    `CK(nS - s, 1)
    `CK(nB - b, 2)
    `CK(nE - e, 1)
    `CK(nN - n, 2)
    `CK(nL - l, 0)
  endtask
  task summarize;
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    cyc(20); rst_n <= 1'b1; cyc(2);
    `CK(nS + nE + nL + nN + nB, 0)
    std_expiry_and_service;
    win_faults;
    swapped_actions;
    summarize;
  end
  initial begin
    #(25 * 2000);
    fails++;
    summarize;
  end
endmodule // tb_top
`default_nettype wire
